// ==== urw_regs.svh ====
// Register map, field positions, reset values and timing counts of the
// resume and remote wakeup block.
// Assumes a 40 MHz aclk and a 32-bit AXI4-Lite register bus.
`ifndef URW_REGS_SVH
`define URW_REGS_SVH

// Byte offsets of the registers
`define URW_OFF_STATUS 8'h00
`define URW_OFF_MASK 8'h04
`define URW_OFF_CLEAR 8'h08
`define URW_OFF_TXVC 8'h0c
`define URW_OFF_CTRL 8'h10
`define URW_OFF_STATE 8'h14

// Interrupt bit positions, shared by status, mask and clear
`define URW_IRQ_WAKE 0
`define URW_IRQ_SUSP 1
`define URW_IRQ_RWDONE 2
`define URW_IRQ_W 3

// Other field positions
`define URW_TXVC_DIS 0
`define URW_CTRL_RWREQ 0
`define URW_STATE_SUSP 0
`define URW_STATE_HOLDOFF 1
`define URW_STATE_KDRIVE 2

// Reset values
`define URW_RST_MASK 3'h0
`define URW_RST_TRANSCEIVER_DISABLE 1'b0

// AXI responses
`define URW_RESP_OKAY 2'h0
`define URW_RESP_SLVERR 2'h2

// Clock rate and times in their own units
`define URW_CLK_HZ 40000000
`define URW_CYC_PER_US (`URW_CLK_HZ / 1000000)
`define URW_T_SUSP_US 3000
`define URW_T_HOLDOFF_US 5000
`define URW_T_DRAIN_MAX_US 10000
`define URW_T_K_MIN_US 1000
`define URW_T_K_MAX_US 15000
`define URW_T_K_HOLD_US 5000
`define URW_T_RES_DEB_US 1

// Derived cycle counts: time times whole cycles per microsecond, which rounds down
`define URW_SUSP_CYC (`URW_T_SUSP_US * `URW_CYC_PER_US)
`define URW_HOLDOFF_CYC (`URW_T_HOLDOFF_US * `URW_CYC_PER_US)
`define URW_DRAIN_MAX_CYC (`URW_T_DRAIN_MAX_US * `URW_CYC_PER_US)
`define URW_K_MIN_CYC (`URW_T_K_MIN_US * `URW_CYC_PER_US)
`define URW_K_MAX_CYC (`URW_T_K_MAX_US * `URW_CYC_PER_US)
`define URW_K_HOLD_CYC (`URW_T_K_HOLD_US * `URW_CYC_PER_US)
`define URW_RES_DEB_CYC (`URW_T_RES_DEB_US * `URW_CYC_PER_US)

`endif

// ==== urw_pkg.sv ====
// Types of the resume and remote wakeup block.
// Assumes nothing beyond a SystemVerilog compiler.
package urw_pkg;

    // Remote wakeup sequencer, Gray coded along the path
    typedef enum logic [1:0] {
        URW_ST_IDLE = 2'b00,
        URW_ST_HOLDOFF = 2'b01,
        URW_ST_KDRIVE = 2'b11,
        URW_ST_DONE = 2'b10
    } urw_state_t;

    // Sampled bus line levels
    typedef struct packed {
        logic dp;
        logic dm;
    } urw_line_t;

    // Pull-up and wakeup current controls toward the board
    typedef struct packed {
        logic dp_pullup;
        logic dm_pullup;
        logic drain;
    } urw_drive_t;

endpackage : urw_pkg

// ==== urw_line_sync.sv ====
// Two-stage synchroniser for the sampled bus lines.
// Assumes the lines change with no relation to aclk.
`timescale 1ns/100ps
`default_nettype none

module urw_line_sync #(
    parameter int WIDTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : urw_line_sync

`default_nettype wire

// ==== urw_resume_wakeup.sv ====
// Suspend, host resume detection and device remote wakeup for a
// full-speed USB device port, with an AXI4-Lite register slave.
// Assumes line_dp/line_dm are raw receiver levels (asynchronous) and
// that master_clk_en comes from clock control logic on aclk.
`timescale 1ns/100ps
`default_nettype none
`include "urw_regs.svh"

module urw_resume_wakeup #(
    parameter int SUSP_CYC = `URW_SUSP_CYC,
    parameter int HOLDOFF_CYC = `URW_HOLDOFF_CYC,
    parameter int K_HOLD_CYC = `URW_K_HOLD_CYC,
    parameter int RES_DEB_CYC = `URW_RES_DEB_CYC,
    parameter int CW = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic master_clk_en,
    input wire logic line_dp,
    input wire logic line_dm,
    output logic dp_pullup_en,
    output logic dm_pullup_en,
    output logic wake_current_en,
    output logic transceiver_disable,
    output logic irq
);

    // K hold kept inside the legal window whatever the parameter says
    function automatic logic [CW-1:0] clamp_k(input int cyc);
        int c;
        c = cyc;
        if (c < `URW_K_MIN_CYC) begin
            c = `URW_K_MIN_CYC;
        end
        if (c > `URW_K_MAX_CYC) begin
            c = `URW_K_MAX_CYC;
        end
        clamp_k = c[CW-1:0];
    endfunction : clamp_k

    // Register select from a byte address
    function automatic logic [2:0] reg_sel(input logic [7:0] addr);
        case (addr)
            `URW_OFF_STATUS: reg_sel = 3'h1;
            `URW_OFF_MASK: reg_sel = 3'h2;
            `URW_OFF_CLEAR: reg_sel = 3'h3;
            `URW_OFF_TXVC: reg_sel = 3'h4;
            `URW_OFF_CTRL: reg_sel = 3'h5;
            `URW_OFF_STATE: reg_sel = 3'h6;
            default: reg_sel = 3'h0;
        endcase
    endfunction : reg_sel

    localparam logic [CW-1:0] SUSP_LAST = CW'(SUSP_CYC - 1);
    localparam logic [CW-1:0] HOLDOFF_N = CW'(HOLDOFF_CYC);
    localparam logic [CW-1:0] K_LAST = clamp_k(K_HOLD_CYC) - CW'(1);
    localparam logic [CW-1:0] DEB_LAST = CW'(RES_DEB_CYC - 1);

    urw_pkg::urw_line_t line_raw;
    urw_pkg::urw_line_t line_s;
    urw_pkg::urw_state_t state;
    urw_pkg::urw_state_t next_state;
    urw_pkg::urw_drive_t next_drive;
    logic [`URW_IRQ_W-1:0] usb_irq_status_reg;
    logic [`URW_IRQ_W-1:0] usb_irq_mask_reg;
    logic [`URW_IRQ_W-1:0] irq_set;
    logic [`URW_IRQ_W-1:0] irq_clr;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic wr_ok;
    logic [2:0] wr_sel;
    logic rd_go;
    logic [2:0] rd_sel;
    logic rw_req;
    logic suspended;
    logic [CW-1:0] idle_cnt;
    logic [CW-1:0] age_cnt;
    logic [CW-1:0] deb_cnt;
    logic [CW-1:0] k_cnt;
    logic line_j;
    logic line_k;
    logic susp_hit;
    logic resume_hit;
    logic boot;

    // Receiver levels brought onto aclk
    assign line_raw.dp = line_dp;
    assign line_raw.dm = line_dm;

    urw_line_sync #(
        .WIDTH(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(line_raw),
        .sync_out(line_s)
    );

    assign line_j = line_s.dp && !line_s.dm;
    assign line_k = !line_s.dp && line_s.dm;

    // Bus events
    assign susp_hit = !suspended && line_j && (idle_cnt == SUSP_LAST);
    assign resume_hit = suspended && line_k && (state != urw_pkg::URW_ST_KDRIVE)
        && (deb_cnt == DEB_LAST);

    // Idle J time toward suspend
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_cnt <= '0;
        end else if (suspended || !line_j) begin
            idle_cnt <= '0;
        end else if (idle_cnt != SUSP_LAST) begin
            idle_cnt <= idle_cnt + CW'(1);
        end
    end

    // Suspended flag; left on host resume, own resume end, or bus reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            suspended <= 1'b0;
        end else if (susp_hit) begin
            suspended <= 1'b1;
        end else if (resume_hit || state == urw_pkg::URW_ST_DONE) begin
            suspended <= 1'b0;
        end else if (suspended && !line_s.dp && !line_s.dm) begin
            suspended <= 1'b0;
        end
    end

    // Time spent in suspend, saturating once the holdoff is met
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            age_cnt <= '0;
        end else if (!suspended) begin
            age_cnt <= '0;
        end else if (age_cnt != HOLDOFF_N) begin
            age_cnt <= age_cnt + CW'(1);
        end
    end

    // Host K debounce while suspended and not driving ourselves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deb_cnt <= '0;
        end else if (!suspended || !line_k || state == urw_pkg::URW_ST_KDRIVE) begin
            deb_cnt <= '0;
        end else if (deb_cnt != DEB_LAST) begin
            deb_cnt <= deb_cnt + CW'(1);
        end
    end

    // Remote wakeup sequencer
    always_comb begin
        next_state = state;
        case (state)
            urw_pkg::URW_ST_IDLE: begin
                if (rw_req && suspended) begin
                    next_state = urw_pkg::URW_ST_HOLDOFF;
                end
            end
            urw_pkg::URW_ST_HOLDOFF: begin
                if (!suspended) begin
                    next_state = urw_pkg::URW_ST_IDLE;
                end else if (age_cnt == HOLDOFF_N) begin
                    next_state = urw_pkg::URW_ST_KDRIVE;
                end
            end
            urw_pkg::URW_ST_KDRIVE: begin
                if (k_cnt == K_LAST) begin
                    next_state = urw_pkg::URW_ST_DONE;
                end
            end
            urw_pkg::URW_ST_DONE: begin
                next_state = urw_pkg::URW_ST_IDLE;
            end
            default: begin
                next_state = urw_pkg::URW_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= urw_pkg::URW_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // K hold length
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            k_cnt <= '0;
        end else if (state != urw_pkg::URW_ST_KDRIVE) begin
            k_cnt <= '0;
        end else begin
            k_cnt <= k_cnt + CW'(1);
        end
    end

    // Pull-up and current controls for the coming state
    always_comb begin
        next_drive.dp_pullup = !transceiver_disable;
        next_drive.dm_pullup = 1'b0;
        next_drive.drain = 1'b0;
        if (next_state == urw_pkg::URW_ST_KDRIVE) begin
            next_drive.dp_pullup = 1'b0;
            next_drive.dm_pullup = 1'b1;
            next_drive.drain = 1'b1;
        end
    end

    // Drive outputs; current draw and K start on the same edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dp_pullup_en <= 1'b0;
            dm_pullup_en <= 1'b0;
            wake_current_en <= 1'b0;
        end else begin
            dp_pullup_en <= next_drive.dp_pullup;
            dm_pullup_en <= next_drive.dm_pullup;
            wake_current_en <= next_drive.drain;
        end
    end

    // Write address and data taken in either order
    assign wr_go = !boot && !s_awready && !s_wready && !s_bvalid;
    assign wr_sel = reg_sel(aw_addr);
    assign wr_ok = wr_go && master_clk_en && (wr_sel != 3'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_awvalid && s_awready) begin
            s_awready <= 1'b0;
            aw_addr <= s_awaddr;
        end else if (boot || wr_go) begin
            s_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_wready <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_wvalid && s_wready) begin
            s_wready <= 1'b0;
            w_data <= s_wdata;
            w_strb <= s_wstrb;
        end else if (boot || wr_go) begin
            s_wready <= 1'b1;
        end
    end

    // Write response; ready flags rise on the first edge after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= `URW_RESP_OKAY;
        end else begin
            boot <= 1'b0;
            if (wr_go) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? `URW_RESP_OKAY : `URW_RESP_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Software controls
    assign irq_clr = (wr_ok && w_strb[0] && (wr_sel == 3'h1 || wr_sel == 3'h3))
        ? w_data[`URW_IRQ_W-1:0] : '0;
    assign irq_set = {state == urw_pkg::URW_ST_DONE, susp_hit, resume_hit};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_irq_mask_reg <= `URW_RST_MASK;
            transceiver_disable <= `URW_RST_TRANSCEIVER_DISABLE;
            rw_req <= 1'b0;
        end else begin
            rw_req <= wr_ok && w_strb[0] && wr_sel == 3'h5 && w_data[`URW_CTRL_RWREQ];
            if (wr_ok && w_strb[0] && wr_sel == 3'h2) begin
                usb_irq_mask_reg <= w_data[`URW_IRQ_W-1:0];
            end
            if (wr_ok && w_strb[0] && wr_sel == 3'h4) begin
                transceiver_disable <= w_data[`URW_TXVC_DIS];
            end
        end
    end

    // Sticky events; a set in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usb_irq_status_reg <= '0;
        end else begin
            usb_irq_status_reg <= (usb_irq_status_reg & ~irq_clr) | irq_set;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(usb_irq_status_reg & usb_irq_mask_reg);
        end
    end

    // Read channel, answered on the same edge that takes the address
    assign rd_go = s_arvalid && s_arready;
    assign rd_sel = reg_sel(s_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= `URW_RESP_OKAY;
        end else if (boot) begin
            s_arready <= 1'b1;
        end else if (rd_go) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rdata <= 32'h0000_0000;
            s_rresp <= `URW_RESP_OKAY;
            if (!master_clk_en || rd_sel == 3'h0) begin
                s_rresp <= `URW_RESP_SLVERR;
            end else begin
                case (rd_sel)
                    3'h1: s_rdata[`URW_IRQ_W-1:0] <= usb_irq_status_reg;
                    3'h2: s_rdata[`URW_IRQ_W-1:0] <= usb_irq_mask_reg;
                    3'h4: s_rdata[`URW_TXVC_DIS] <= transceiver_disable;
                    3'h6: begin
                        s_rdata[`URW_STATE_SUSP] <= suspended;
                        s_rdata[`URW_STATE_HOLDOFF] <= state == urw_pkg::URW_ST_HOLDOFF;
                        s_rdata[`URW_STATE_KDRIVE] <= state == urw_pkg::URW_ST_KDRIVE;
                    end
                    default: s_rdata <= 32'h0000_0000;
                endcase
            end
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end

endmodule : urw_resume_wakeup

`default_nettype wire

// ==== urw_resume_wakeup_assertions.sv ====
// Port-level checker for the resume and remote wakeup block.
// Assumes the single aclk domain and the bind at the foot of this file.
`timescale 1ns/100ps
`default_nettype none

module urw_resume_wakeup_assertions #(
    parameter int SUSP_CYC = 50,
    parameter int HOLDOFF_CYC = 100
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic [31:0] s_rdata,
    input wire logic [1:0] s_rresp,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic master_clk_en,
    input wire logic line_dp,
    input wire logic line_dm,
    input wire logic dp_pullup_en,
    input wire logic dm_pullup_en,
    input wire logic wake_current_en,
    input wire logic transceiver_disable,
    input wire logic irq
);
    localparam int K_MIN = 40000; // 1 ms of aclk
    localparam int K_MAX = 600000; // 15 ms of aclk
    logic [31:0] kcnt;
    logic [31:0] jcnt;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Length of the K drive so far
    always_ff @(posedge aclk) begin
        kcnt <= dm_pullup_en ? kcnt + 32'h1 : 32'h0;
    end

    // Idle J time on the raw lines, ahead of the synchroniser
    always_ff @(posedge aclk) begin
        jcnt <= (aresetn && line_dp && !line_dm) ? jcnt + 32'h1 : 32'h0;
    end

    a_k_lines_swap: assert property (dm_pullup_en |-> !dp_pullup_en)
        else $error("K drive with D+ pull-up still on");
    a_k_current_paired: assert property (wake_current_en == dm_pullup_en)
        else $error("Wakeup current and K drive out of step");
    a_k_min_hold: assert property ($fell(dm_pullup_en) |-> kcnt >= K_MIN)
        else $error("K drive shorter than the least hold");
    a_k_max_hold: assert property (kcnt <= K_MAX)
        else $error("K drive longer than the longest hold");
    a_k_after_holdoff: assert property ($rose(dm_pullup_en) |->
        jcnt >= SUSP_CYC + HOLDOFF_CYC - 2)
        else $error("K drive began before suspend and holdoff");
    a_err_clk_off: assert property (s_arvalid && s_arready && !master_clk_en
        |=> s_rvalid && s_rresp == 2'h2 && s_rdata == 32'h0)
        else $error("Read with master clock off not refused");
    a_rvalid_stands: assert property (s_rvalid && !s_rready
        |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp))
        else $error("Read answer dropped before rready");
    a_bvalid_stands: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("Write answer dropped before bready");
    a_pullup_transceiver_disable: assert property ($past(aresetn) && !dm_pullup_en
        && !$past(dm_pullup_en) && !$past(dm_pullup_en, 2) && $stable(transceiver_disable)
        |-> dp_pullup_en == !transceiver_disable)
        else $error("D+ pull-up disagrees with transceiver disable");
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !dm_pullup_en && !s_bvalid)
        else $error("Outputs active straight after reset");

    c_k_drive: cover property ($rose(dm_pullup_en));
    c_irq_up: cover property ($rose(irq));
    c_refused: cover property (s_rvalid && s_rresp == 2'h2);
endmodule : urw_resume_wakeup_assertions

bind urw_resume_wakeup urw_resume_wakeup_assertions #(
    .SUSP_CYC(SUSP_CYC),
    .HOLDOFF_CYC(HOLDOFF_CYC)
) urw_resume_wakeup_assertions_i (.aclk, .aresetn, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .s_bresp, .s_bvalid, .s_bready, .master_clk_en,
    .line_dp, .line_dm, .dp_pullup_en, .dm_pullup_en, .wake_current_en,
    .transceiver_disable, .irq);

`default_nettype wire

// ==== urw_host_model.sv ====
// Host side of the bus: idle, resume K or bus reset SE0.
// Assumes host pull-downs, so a released line sits at its pull-up level.
`timescale 1ns/100ps
`default_nettype none

module urw_host_model (
    input wire logic dp_pullup_en,
    input wire logic dm_pullup_en,
    input wire logic [1:0] mode,
    output logic line_dp,
    output logic line_dm
);
    // Line levels from host drive or pull-ups
    always_comb begin
        case (mode)
            2'h1: begin
                line_dp = 1'b0;
                line_dm = 1'b1;
            end
            2'h2: begin
                line_dp = 1'b0;
                line_dm = 1'b0;
            end
            default: begin
                line_dp = dp_pullup_en;
                line_dm = dm_pullup_en;
            end
        endcase
    end
endmodule : urw_host_model

`default_nettype wire

// ==== urw_resume_wakeup_bench.sv ====
// Self-checking bench for the resume and remote wakeup block.
// Assumes the host model on the lines and shortened suspend counts.
`timescale 1ns/100ps
`default_nettype none
`include "urw_regs.svh"

module urw_resume_wakeup_bench;
    localparam int SUSP = 400;
    localparam int HOLD = 400;
    localparam int DEB = 4;
    logic aclk = 1'b0;
    logic aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic s_arvalid, s_arready, s_rvalid, s_rready, master_clk_en, line_dp, line_dm;
    logic dp_pullup_en, dm_pullup_en, wake_current_en, transceiver_disable, irq;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, d;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp, host_mode, r;
    int errors, comparisons, seed, st, n;

    urw_resume_wakeup #(.SUSP_CYC(SUSP), .HOLDOFF_CYC(HOLD), .RES_DEB_CYC(DEB),
        .K_HOLD_CYC(`URW_K_MIN_CYC))
        urw_resume_wakeup_i (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .master_clk_en,
        .line_dp, .line_dm, .dp_pullup_en, .dm_pullup_en, .wake_current_en,
        .transceiver_disable, .irq);
    urw_host_model urw_host_model_i (.dp_pullup_en, .dm_pullup_en, .mode(host_mode),
        .line_dp, .line_dm);

    // 40 MHz clock
    always #12.5 aclk = ~aclk;

    task complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task tmo(input string what);
        errors++;
        $display("[FAIL] %s expected done seen timeout", what);
        complete_run();
    endtask : tmo

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Write with address and data offered together
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int k;
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        k = 0;
        s_awaddr <= a;
        s_wdata <= v;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        while ((aw || w || !(s_bvalid && s_bready)) && k < 100) begin
            @(posedge aclk);
            if (s_bvalid && !s_bready) s_bready <= 1'b1;
            if (aw && s_awready) begin
                aw = 1'b0;
                s_awvalid <= 1'b0;
            end
            if (w && s_wready) begin
                w = 1'b0;
                s_wvalid <= 1'b0;
            end
            k++;
        end
        if (k >= 100) tmo("write");
        rs = s_bresp;
        s_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    // Read and compare data and response
    task rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int k;
        logic ar;
        ar = 1'b1;
        k = 0;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        while ((ar || !(s_rvalid && s_rready)) && k < 100) begin
            @(posedge aclk);
            if (s_rvalid && !s_rready) s_rready <= 1'b1;
            if (ar && s_arready) begin
                ar = 1'b0;
                s_arvalid <= 1'b0;
            end
            k++;
        end
        if (k >= 100) tmo("read");
        d = s_rdata;
        s_rready <= 1'b0;
        chk("rdata", d, exp);
        chk("rresp", {30'h0, s_rresp}, {30'h0, er});
        @(posedge aclk);
    endtask : rchk

    task wait_k(input logic lvl, input int lim);
        n = 0;
        while (dm_pullup_en !== lvl && n < lim) begin
            @(posedge aclk);
            n++;
        end
        if (n >= lim) tmo("k drive");
    endtask : wait_k

    initial begin
        seed = 32'he14afd94;
        errors = 0;
        comparisons = 0;
        st = 0;
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, host_mode} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'hf;
        master_clk_en = 1'b1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // Reset values, then an unmapped address
        for (int i = 0; i < 6; i++) rchk(8'(i * 4), 32'h0, 2'h0);
        rchk(8'h18, 32'h0, 2'h2);
        // Master clock off: access refused
        master_clk_en <= 1'b0;
        rchk(`URW_OFF_MASK, 32'h0, 2'h2);
        wr(`URW_OFF_MASK, 32'h7, r);
        chk("wresp", r, 2'h2);
        master_clk_en <= 1'b1;
        rchk(`URW_OFF_MASK, 32'h0, 2'h0);
        // Random mask read back, then masked off again
        n = $random(seed);
        wr(`URW_OFF_MASK, 32'(n), r);
        rchk(`URW_OFF_MASK, 32'(n) & 32'h7, 2'h0);
        wr(`URW_OFF_MASK, 32'h0, r);
        // Wakeup request outside suspend
        wr(`URW_OFF_CTRL, 32'h1, r);
        repeat (20) @(posedge aclk);
        chk("dm_pullup", dm_pullup_en, 1'b0);
        rchk(`URW_OFF_STATE, 32'h0, 2'h0);
        // Transceiver disable drops the D+ pull-up
        wr(`URW_OFF_TXVC, 32'h1, r);
        repeat (2) @(posedge aclk);
        chk("transceiver_disable", transceiver_disable, 1'b1);
        chk("dp_pullup", dp_pullup_en, 1'b0);
        wr(`URW_OFF_TXVC, 32'h0, r);
        repeat (2) @(posedge aclk);
        chk("dp_pullup", dp_pullup_en, 1'b1);
        // Suspend, then resume from the host
        repeat (SUSP + 10) @(posedge aclk);
        st = 2;
        rchk(`URW_OFF_STATUS, 32'(st), 2'h0);
        host_mode <= 2'h1;
        repeat (DEB + 4) @(posedge aclk);
        host_mode <= 2'h0;
        repeat (4) @(posedge aclk);
        st = 3;
        rchk(`URW_OFF_STATUS, 32'(st), 2'h0);
        chk("irq", irq, 1'b0);
        wr(`URW_OFF_MASK, 32'h1, r);
        repeat (3) @(posedge aclk);
        chk("irq", irq, 1'b1);
        master_clk_en <= 1'b0;
        wr(`URW_OFF_CLEAR, 32'h1, r);
        chk("wresp", r, 2'h2);
        master_clk_en <= 1'b1;
        rchk(`URW_OFF_STATUS, 32'(st), 2'h0);
        wr(`URW_OFF_CLEAR, 32'h3, r);
        rchk(`URW_OFF_STATUS, 32'h0, 2'h0);
        chk("irq", irq, 1'b0);
        // Remote wakeup from suspend
        repeat (SUSP + 10) @(posedge aclk);
        wr(`URW_OFF_CTRL, 32'h1, r);
        wait_k(1'b1, HOLD + 40);
        chk("dp_pullup", dp_pullup_en, 1'b0);
        chk("current", wake_current_en, 1'b1);
        rchk(`URW_OFF_STATE, 32'h5, 2'h0);
        wait_k(1'b0, 41000);
        chk("k_len_ok", {31'h0, n >= 39990 && n <= 600000}, 32'h1);
        repeat (4) @(posedge aclk);
        rchk(`URW_OFF_STATUS, 32'h6, 2'h0);
        // Suspend again, then a bus reset SE0 from the host leaves it
        repeat (SUSP + 10) @(posedge aclk);
        rchk(`URW_OFF_STATE, 32'h1, 2'h0);
        host_mode <= 2'h2;
        repeat (6) @(posedge aclk);
        rchk(`URW_OFF_STATE, 32'h0, 2'h0);
        complete_run();
    end
endmodule : urw_resume_wakeup_bench

`default_nettype wire
